/* File: hw/rcr_regs.svh */
// Register map, field positions, reset values and timing constants of the radio control block
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// Device register offsets
`define RCR_OFS_CHANNEL 8'h00
`define RCR_OFS_STATUS 8'h01
`define RCR_OFS_IRQ_CFG 8'h02
`define RCR_OFS_TX_POWER 8'h03
`define RCR_OFS_AMP_BOOST 8'h04
`define RCR_OFS_STRENGTH 8'h20
`define RCR_OFS_QUEUE_SEL 8'h28

// Reset values
`define RCR_RST_CHANNEL 7'h28
`define RCR_RST_BYTE 8'h00
`define RCR_RST_BOOST_RSV 7'h11
`define RCR_CARRIER_BASE 12'h960

// Field positions
`define RCR_CFG_POL_BIT 7
`define RCR_ST_RX_READY 5
`define RCR_ST_TX_DONE 4
`define RCR_ST_RETRY 3
`define RCR_ST_STRENGTH 2
`define RCR_ST_TXQ 1
`define RCR_ST_RXQ 0
`define RCR_EN_TXQ 2
`define RCR_EN_RXQ 1
`define RCR_EN_STRENGTH 0
`define RCR_PWR_HI 3
`define RCR_PWR_LO 2
`define RCR_BOOST_BIT 7
`define RCR_SS_LOWEST_BIT 6
`define RCR_SS_CONT_BIT 5
`define RCR_SS_ONESHOT_BIT 4
`define RCR_SS_UPPER_HI 3

// Timing at the 250 MHz reference clock
`define RCR_CLK_MHZ 250
`define RCR_EXT_RST_NS 5000
`define RCR_EXT_RST_CYC (((`RCR_EXT_RST_NS * `RCR_CLK_MHZ) + 999) / 1000)
`define RCR_POR_MS 50
`define RCR_POR_CYC (`RCR_POR_MS * `RCR_CLK_MHZ * 1000)
`define RCR_XTAL_US 1500
`define RCR_XTAL_CYC (`RCR_XTAL_US * `RCR_CLK_MHZ)
`define RCR_RST_HOLD_NS 6000
`define RCR_RST_HOLD_CYC (((`RCR_RST_HOLD_NS * `RCR_CLK_MHZ) + 999) / 1000)
`define RCR_MEAS_CYC 32

// Host controller registers, word indexes taken from address bits 3:2
`define RCR_HOFS_CMD 2'h0
`define RCR_HOFS_STATUS 2'h1
`define RCR_HOFS_RESET 2'h2
`define RCR_HCMD_WR_BIT 16
`define RCR_HCMD_IND_BIT 17

`endif

/* File: hw/rcr_pkg.sv */
// Types shared by both ends of the radio control link
package rcr_pkg;
  // Device operating phase
  typedef enum logic [1:0] {
    RCR_DEV_POR = 2'b00,
    RCR_DEV_RUN = 2'b01,
    RCR_DEV_EXT = 2'b10
  } rcr_dev_state_type;

  // Host controller phase
  typedef enum logic [1:0] {
    RCR_HOST_IDLE = 2'b00,
    RCR_HOST_LINK = 2'b01,
    RCR_HOST_RST = 2'b10,
    RCR_HOST_XTAL = 2'b11
  } rcr_host_state_type;

  // Resolved transmitter output level
  typedef enum logic [2:0] {
    RCR_LVL_M20 = 3'b000,
    RCR_LVL_M14 = 3'b001,
    RCR_LVL_M8 = 3'b010,
    RCR_LVL_0 = 3'b011,
    RCR_LVL_P4 = 3'b100
  } rcr_level_type;
endpackage

/* File: hw/rcr_link_if.sv */
// Register access link between the host controller and the radio device
`timescale 1ns/1ps
interface rcr_link_if;
  logic reset_n;     // Reset pin, host drives, active low
  logic req;         // Access request level
  logic wr;          // 1 write, 0 read
  logic ind;         // Indirect register space
  logic [7:0] addr;  // Register offset
  logic [7:0] wdata; // Write byte
  logic ack;         // One-cycle answer
  logic [7:0] rdata; // Read byte, valid with ack
  logic irq;         // Interrupt pin

  modport dev (input reset_n, input req, input wr, input ind, input addr, input wdata,
               output ack, output rdata, output irq);
  modport host (output reset_n, output req, output wr, output ind, output addr,
                output wdata, input ack, input rdata, input irq);
endinterface

/* File: hw/rcr_device.sv */
// Radio device end: registers, interrupt logic, strength measurement and reset handling
//
// Design decision made here: the register link device port (rcr_link_if.dev).
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_device
  import rcr_pkg::*;
#(
  parameter int POR_CYCLES = `RCR_POR_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // Link to host
  rcr_link_if.dev LINK,
  // Radio event inputs
  input wire logic RX_READY_IN,
  input wire logic TX_DONE_IN,
  input wire logic RETRY_LIMIT_IN,
  input wire logic [1:0] TX_QUEUE_STATE_IN,
  input wire logic RX_QUEUE_NONEMPTY_IN,
  input wire logic [4:0] STRENGTH_IN,
  input wire logic ADDR_MATCH_IN,
  // Radio settings and status
  output logic [6:0] RF_CHANNEL_OUT,
  output logic [11:0] CARRIER_MHZ_OUT,
  output rcr_level_type OUTPUT_LEVEL_OUT,
  output logic MEASURING_OUT,
  output logic [4:0] PACKET_STRENGTH_OUT,
  output logic IDLE_OUT
);
  // Phase and reset counters
  rcr_dev_state_type state_q, state_d;
  logic [23:0] por_cnt_q; // Power-on delay counter
  logic [11:0] low_cnt_q; // Reset pin low time

  // Registers
  logic [6:0] channel_q;
  logic [5:0] status_q;
  logic [7:0] irq_cfg_q;
  logic [1:0] power_q;
  logic boost_q;
  logic [3:0] ss_upper_q;
  logic ss_lowest_q;
  logic ss_cont_q;
  logic ss_oneshot_q;
  logic [1:0] queue_sel_q;
  logic [4:0] pkt_strength_q;

  // Link answer
  logic ack_q;
  logic [7:0] rdata_q;
  logic irq_q;

  // Event edge history
  logic [1:0] txq_prev_q;
  logic rxq_prev_q;
  logic [5:0] meas_cnt_q; // Measurement duration counter

  // Link decode
  wire running = (state_q == RCR_DEV_RUN);
  wire take = running & LINK.req & ~ack_q;
  wire wr_take = take & LINK.wr;
  wire dir = ~LINK.ind;
  wire hit_chan = dir & (LINK.addr == `RCR_OFS_CHANNEL);
  wire hit_stat = dir & (LINK.addr == `RCR_OFS_STATUS);
  wire hit_cfg = dir & (LINK.addr == `RCR_OFS_IRQ_CFG);
  wire hit_pwr = dir & (LINK.addr == `RCR_OFS_TX_POWER);
  wire hit_ss = dir & (LINK.addr == `RCR_OFS_STRENGTH);
  wire hit_qsel = dir & (LINK.addr == `RCR_OFS_QUEUE_SEL);
  wire hit_boost = LINK.ind & (LINK.addr == `RCR_OFS_AMP_BOOST);

  // Reset pin qualification: a long enough low means reset
  wire pin_low = ~LINK.reset_n;
  wire ext_hit = pin_low & (low_cnt_q == 12'(`RCR_EXT_RST_CYC));
  wire soft_rst = (state_q != RCR_DEV_RUN); // Registers held at defaults

  // Interrupt sources, one per status bit
  wire txq_event = (TX_QUEUE_STATE_IN == queue_sel_q) &
                   (txq_prev_q != queue_sel_q);
  wire rxq_event = RX_QUEUE_NONEMPTY_IN & ~rxq_prev_q;
  wire meas_active = ss_oneshot_q | ss_cont_q;
  wire meas_done = meas_active & (meas_cnt_q == 6'(`RCR_MEAS_CYC - 1));
  logic [5:0] set_vec;
  assign set_vec[`RCR_ST_RX_READY] = RX_READY_IN;
  assign set_vec[`RCR_ST_TX_DONE] = TX_DONE_IN;
  assign set_vec[`RCR_ST_RETRY] = RETRY_LIMIT_IN;
  assign set_vec[`RCR_ST_STRENGTH] = meas_done;
  assign set_vec[`RCR_ST_TXQ] = txq_event;
  assign set_vec[`RCR_ST_RXQ] = rxq_event;
  wire [5:0] clr_vec = (wr_take & hit_stat) ? LINK.wdata[5:0] : 6'h00;

  // Enable bits reordered to status layout
  logic [5:0] en_vec;
  assign en_vec[`RCR_ST_RX_READY] = irq_cfg_q[`RCR_ST_RX_READY];
  assign en_vec[`RCR_ST_TX_DONE] = irq_cfg_q[`RCR_ST_TX_DONE];
  assign en_vec[`RCR_ST_RETRY] = irq_cfg_q[`RCR_ST_RETRY];
  assign en_vec[`RCR_ST_STRENGTH] = irq_cfg_q[`RCR_EN_STRENGTH];
  assign en_vec[`RCR_ST_TXQ] = irq_cfg_q[`RCR_EN_TXQ];
  assign en_vec[`RCR_ST_RXQ] = irq_cfg_q[`RCR_EN_RXQ];
  wire pending = |(status_q & en_vec);
  wire irq_level = irq_cfg_q[`RCR_CFG_POL_BIT] ? pending : ~pending;

  // Read mux, reserved bits read zero except the boost register's fixed 7'h11 pattern
  wire [7:0] rd_chan = {1'b0, channel_q};
  wire [7:0] rd_stat = {2'b00, status_q};
  wire [7:0] rd_pwr = {4'h0, power_q, 2'b00};
  wire [7:0] rd_ss = {1'b0, ss_lowest_q, ss_cont_q, ss_oneshot_q, ss_upper_q};
  wire [7:0] rd_qsel = {6'h00, queue_sel_q};
  wire [7:0] rd_boost = {boost_q, `RCR_RST_BOOST_RSV}; // Reserved pattern is read-only
  wire [7:0] rd_val = hit_chan ? rd_chan :
                      hit_stat ? rd_stat :
                      hit_cfg ? irq_cfg_q :
                      hit_pwr ? rd_pwr :
                      hit_ss ? rd_ss :
                      hit_qsel ? rd_qsel :
                      hit_boost ? rd_boost : 8'h00;

  // Phase sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      RCR_DEV_POR: begin
        // Wait out the power-on delay, then idle
        if (ext_hit) begin
          state_d = RCR_DEV_EXT;
        end else if (por_cnt_q == 24'(POR_CYCLES - 1)) begin
          state_d = RCR_DEV_RUN;
        end
      end
      RCR_DEV_RUN: begin
        // Any activity is dropped on a qualified reset
        if (ext_hit) begin
          state_d = RCR_DEV_EXT;
        end
      end
      RCR_DEV_EXT: begin
        // Only the pin going high ends it; nothing else is looked at
        if (LINK.reset_n) begin
          state_d = RCR_DEV_RUN;
        end
      end
      default: begin
        state_d = RCR_DEV_POR;
      end
    endcase
  end

  // Phase register and counters
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= RCR_DEV_POR;
      por_cnt_q <= 24'h000000;
      low_cnt_q <= 12'h000;
    end else begin
      state_q <= state_d;
      por_cnt_q <= (state_q == RCR_DEV_POR) ? por_cnt_q + 24'h000001 : 24'h000000;
      // Saturating low-time counter; a glitch shorter than the limit is ignored
      if (!pin_low) begin
        low_cnt_q <= 12'h000;
      end else if (!ext_hit) begin
        low_cnt_q <= low_cnt_q + 12'h001;
      end
    end
  end

  // Software registers, forced to defaults outside the run phase
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      channel_q <= `RCR_RST_CHANNEL;
      irq_cfg_q <= `RCR_RST_BYTE;
      power_q <= 2'b00;
      boost_q <= 1'b0;
      queue_sel_q <= 2'b00;
    end else if (soft_rst) begin
      channel_q <= `RCR_RST_CHANNEL;
      irq_cfg_q <= `RCR_RST_BYTE;
      power_q <= 2'b00;
      boost_q <= 1'b0;
      queue_sel_q <= 2'b00;
    end else if (wr_take) begin
      if (hit_chan) channel_q <= LINK.wdata[6:0];
      if (hit_cfg) irq_cfg_q <= LINK.wdata;
      if (hit_pwr) power_q <= LINK.wdata[`RCR_PWR_HI:`RCR_PWR_LO];
      if (hit_boost) boost_q <= LINK.wdata[`RCR_BOOST_BIT];
      if (hit_qsel) queue_sel_q <= LINK.wdata[1:0];
    end
  end

  // Status flags: an event in the clearing cycle survives
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      status_q <= 6'h00;
    end else if (soft_rst) begin
      status_q <= 6'h00;
    end else begin
      status_q <= (status_q & ~clr_vec) | set_vec;
    end
  end

  // Strength register and measurement engine
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ss_upper_q <= 4'h0;
      ss_lowest_q <= 1'b0;
      ss_cont_q <= 1'b0;
      ss_oneshot_q <= 1'b0;
      meas_cnt_q <= 6'h00;
      pkt_strength_q <= 5'h00;
    end else if (soft_rst) begin
      ss_upper_q <= 4'h0;
      ss_lowest_q <= 1'b0;
      ss_cont_q <= 1'b0;
      ss_oneshot_q <= 1'b0;
      meas_cnt_q <= 6'h00;
      pkt_strength_q <= 5'h00;
    end else begin
      // Counter restarts whenever nothing is requested
      meas_cnt_q <= (meas_active & ~meas_done) ? meas_cnt_q + 6'h01 : 6'h00;
      if (wr_take & hit_ss) begin
        ss_cont_q <= LINK.wdata[`RCR_SS_CONT_BIT];
        ss_oneshot_q <= LINK.wdata[`RCR_SS_ONESHOT_BIT];
        ss_upper_q <= LINK.wdata[`RCR_SS_UPPER_HI:0];
        ss_lowest_q <= LINK.wdata[`RCR_SS_LOWEST_BIT];
      end else if (meas_done) begin
        ss_oneshot_q <= 1'b0;
      end
      // Result lands in its split fields, measured on the current channel
      if (meas_done) begin
        ss_upper_q <= STRENGTH_IN[4:1];
        ss_lowest_q <= STRENGTH_IN[0];
      end
      // Packet strength captured on address match while continuous measurement is on
      if (ADDR_MATCH_IN & ss_cont_q) begin
        pkt_strength_q <= STRENGTH_IN;
      end
    end
  end

  // Link answer and pin
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_q <= 1'b1;
      txq_prev_q <= 2'b00;
      rxq_prev_q <= 1'b0;
    end else begin
      ack_q <= take;
      if (take) rdata_q <= rd_val;
      irq_q <= irq_level;
      txq_prev_q <= TX_QUEUE_STATE_IN;
      rxq_prev_q <= RX_QUEUE_NONEMPTY_IN;
    end
  end

  // Resolved output level; boost overrides the field
  wire rcr_level_type level = boost_q ? RCR_LVL_P4 :
                              rcr_level_type'({1'b0, power_q});

  // Outputs
  assign LINK.ack = ack_q;
  assign LINK.rdata = rdata_q;
  assign LINK.irq = irq_q;
  assign RF_CHANNEL_OUT = channel_q;
  assign CARRIER_MHZ_OUT = `RCR_CARRIER_BASE + {5'h00, channel_q};
  assign OUTPUT_LEVEL_OUT = level;
  assign MEASURING_OUT = meas_active;
  assign PACKET_STRENGTH_OUT = pkt_strength_q;
  assign IDLE_OUT = running;
endmodule // rcr_device

/* File: hw/rcr_host.sv */
// Host controller end: Avalon-MM command registers driving the device link
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_host
  import rcr_pkg::*;
#(
  parameter int XTAL_CYCLES = `RCR_XTAL_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Link to device
  rcr_link_if.host LINK
);
  rcr_host_state_type state_q;
  logic [19:0] cnt_q;   // Reset hold and quiet-time counter
  logic done_q;         // Bus answer cycle
  logic [31:0] rdata_q;
  logic req_q;
  logic wr_q;
  logic ind_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] result_q; // Last read byte
  logic rst_n_q;

  // Bus decode
  wire [1:0] word = AVS_ADDRESS_IN[3:2];
  wire idle = (state_q == RCR_HOST_IDLE);
  wire cmd_wr = AVS_WRITE_IN & (word == `RCR_HOFS_CMD);
  wire rst_wr = AVS_WRITE_IN & (word == `RCR_HOFS_RESET) & AVS_WRITEDATA_IN[0];
  // Commands wait while the link is busy or the device is settling
  wire blocked = (cmd_wr | rst_wr) & ~idle;
  wire accept = (AVS_READ_IN | AVS_WRITE_IN) & ~done_q & ~blocked;
  wire [31:0] status_word = {22'h000000, LINK.irq, result_q, ~idle};
  wire [31:0] rd_val = (word == `RCR_HOFS_STATUS) ? status_word :
                       (word == `RCR_HOFS_CMD) ? {16'h0000, wdata_q, addr_q} : 32'h00000000;
  wire hold_end = (cnt_q == 20'(`RCR_RST_HOLD_CYC - 1));
  wire xtal_end = (cnt_q == 20'(XTAL_CYCLES - 1));

  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~done_q;

  // Bus answer
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      done_q <= accept;
      if (accept) rdata_q <= rd_val;
    end
  end

  // Link sequencing
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= RCR_HOST_IDLE;
      cnt_q <= 20'h00000;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      ind_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      result_q <= 8'h00;
      rst_n_q <= 1'b1;
    end else begin
      case (state_q)
        RCR_HOST_IDLE: begin
          // Launch a register access or a device reset
          if (accept & cmd_wr) begin
            addr_q <= AVS_WRITEDATA_IN[7:0];
            wdata_q <= AVS_WRITEDATA_IN[15:8];
            wr_q <= AVS_WRITEDATA_IN[`RCR_HCMD_WR_BIT];
            ind_q <= AVS_WRITEDATA_IN[`RCR_HCMD_IND_BIT];
            req_q <= 1'b1;
            state_q <= RCR_HOST_LINK;
          end else if (accept & rst_wr) begin
            rst_n_q <= 1'b0;
            cnt_q <= 20'h00000;
            state_q <= RCR_HOST_RST;
          end
        end
        RCR_HOST_LINK: begin
          // Hold the request until the device answers
          if (LINK.ack) begin
            req_q <= 1'b0;
            if (!wr_q) result_q <= LINK.rdata;
            state_q <= RCR_HOST_IDLE;
          end
        end
        RCR_HOST_RST: begin
          // Hold the pin low past the qualification time
          cnt_q <= cnt_q + 20'h00001;
          if (hold_end) begin
            rst_n_q <= 1'b1;
            cnt_q <= 20'h00000;
            state_q <= RCR_HOST_XTAL;
          end
        end
        RCR_HOST_XTAL: begin
          // Quiet time for the oscillator to start
          cnt_q <= cnt_q + 20'h00001;
          if (xtal_end) begin
            state_q <= RCR_HOST_IDLE;
          end
        end
        default: begin
          state_q <= RCR_HOST_IDLE;
        end
      endcase
    end
  end

  // Outputs
  assign AVS_READDATA_OUT = rdata_q;
  assign LINK.reset_n = rst_n_q;
  assign LINK.req = req_q;
  assign LINK.wr = wr_q;
  assign LINK.ind = ind_q;
  assign LINK.addr = addr_q;
  assign LINK.wdata = wdata_q;
endmodule // rcr_host

/* File: testbench/rcr_link_asserts.sv */
// Concurrent checks on the register link between host controller and radio device
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_link_asserts (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // Link signals
  input wire logic reset_n,
  input wire logic req,
  input wire logic wr,
  input wire logic ind,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic irq
);
  // Margin past the device's own low count before its outputs must be quiet
  localparam int EXT_QUIET = `RCR_EXT_RST_CYC + 10;
  logic [15:0] low_q; // Consecutive low samples of the reset pin
  logic [15:0] low_d; // Next value, saturating so a long hold never wraps
  default clocking def_cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  assign low_d = reset_n ? 16'h0000 : ((low_q == 16'hFFFF) ? low_q : low_q + 16'h0001);
  // Low-time counter
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_d;
    end
  end
  ack_one_cycle_a: // one-cycle answer
    assert property (ack |=> !ack) else $error("link ack longer than one cycle");
  ack_needs_req_a: // answer only to a pending request
    assert property (ack |-> req && $past(req)) else $error("link ack without request");
  req_holds_a: // request and its qualifiers steady until answered
    assert property (req && !ack |=> req && $stable({wr, ind, addr, wdata}))
    else $error("link request changed before ack");
  req_release_a: // request dropped right after the answer
    assert property (ack |=> !req) else $error("link request held after ack");
  ack_delay_a: // device in run answers on the next cycle
    assert property ($rose(req) |=> ack) else $error("link ack late");
  rst_quiet_a:
    assert property ($rose(reset_n) |=> !req [*8]) else $error("request during oscillator start");
  ext_quiet_a:
    assert property (low_q >= EXT_QUIET |-> irq && !ack) else $error("device active in reset");
  rst_irq_a:
    assert property ($rose(reset_n) |-> irq) else $error("interrupt pin not idle after reset");
  rdata_hold_a: // read byte held between answers
    assert property (reset_n && $past(reset_n) && $changed(rdata) |-> ack)
    else $error("link read byte changed without ack");
endmodule // rcr_link_asserts

/* File: testbench/tb_radio_ctrl_irq_rssi_regs.sv */
// Self-checking bench joining host controller and radio device over their link
`timescale 1ns/1ps
module tb_radio_ctrl_irq_rssi_regs
  import rcr_pkg::*;
;
  localparam int LIMIT = 20000; // Whole run fits well inside this
  logic ref_clk, reset_n; // Clock and reset
  logic [3:0] av_addr; // Avalon master side
  logic av_rd, av_wr, av_wait;
  logic [31:0] av_wdata, av_rdata;
  logic rx_ready, tx_done, retry_lim, rxq, addr_match; // Radio events
  logic [1:0] txq;
  logic [4:0] strength;
  logic [6:0] rf_ch; // Device settings seen
  logic [11:0] carrier;
  rcr_level_type level;
  logic measuring, idle;
  logic [4:0] pkt_strength;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  rcr_link_if rcr_link_if_inst ();
  wire irq_pin = rcr_link_if_inst.irq;
  // Short counts keep the run brief
  rcr_host #(.XTAL_CYCLES(10)) rcr_host_inst (
    .REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .AVS_ADDRESS_IN(av_addr),
    .AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata),
    .AVS_READDATA_OUT(av_rdata), .AVS_WAITREQUEST_OUT(av_wait), .LINK(rcr_link_if_inst));
  rcr_device #(.POR_CYCLES(20)) rcr_device_inst (
    .REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .LINK(rcr_link_if_inst),
    .RX_READY_IN(rx_ready), .TX_DONE_IN(tx_done), .RETRY_LIMIT_IN(retry_lim),
    .TX_QUEUE_STATE_IN(txq), .RX_QUEUE_NONEMPTY_IN(rxq), .STRENGTH_IN(strength),
    .ADDR_MATCH_IN(addr_match), .RF_CHANNEL_OUT(rf_ch), .CARRIER_MHZ_OUT(carrier),
    .OUTPUT_LEVEL_OUT(level), .MEASURING_OUT(measuring),
    .PACKET_STRENGTH_OUT(pkt_strength), .IDLE_OUT(idle));
  rcr_link_asserts rcr_link_asserts_inst (
    .REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .reset_n(rcr_link_if_inst.reset_n),
    .req(rcr_link_if_inst.req), .wr(rcr_link_if_inst.wr), .ind(rcr_link_if_inst.ind),
    .addr(rcr_link_if_inst.addr), .wdata(rcr_link_if_inst.wdata),
    .ack(rcr_link_if_inst.ack), .rdata(rcr_link_if_inst.rdata), .irq(rcr_link_if_inst.irq));
  // Clock at 250 MHz
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      $display("BAD timeout exp %0d got %0d", LIMIT, cyc);
      final_report();
    end
  end
  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon access; entered just after an edge, ends one edge after release
  task automatic av_acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    av_wr <= w;
    av_rd <= !w;
    av_addr <= a;
    av_wdata <= d;
    do @(posedge ref_clk); while (av_wait !== 1'h0);
    q = av_rdata;
    av_wr <= 1'h0;
    av_rd <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Device register access: command, then poll busy
  task automatic dev_acc(input logic w, input logic ind, input logic [7:0] ofs,
                         input logic [7:0] d, output logic [7:0] b);
    logic [31:0] q;
    int n;
    n = 0;
    av_acc(1'h1, 4'h0, {14'h0000, ind, w, d, ofs}, q);
    do begin
      av_acc(1'h0, 4'h4, 32'h0, q);
      n++;
    end while (q[0] !== 1'h0 && n < 400);
    chk("link busy", 12'h000, 12'(q[0]));
    b = q[8:1];
  endtask
  // Direct write
  task automatic wr8(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] b;
    dev_acc(1'h1, 1'h0, ofs, d, b);
  endtask
  // Direct read and compare
  task automatic rd_chk(input string nm, input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] b;
    dev_acc(1'h0, 1'h0, ofs, 8'h00, b);
    chk(nm, 12'(e), 12'(b));
  endtask
  // One-cycle event pulse on the receive-ready input
  task automatic pulse_rx();
    rx_ready <= 1'h1;
    @(posedge ref_clk);
    rx_ready <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Defaults after power-on
  task automatic t_defaults();
    logic [7:0] b;
    chk("idle", 12'h001, 12'(idle));
    chk("irq idle", 12'h001, 12'(irq_pin));
    chk("level", 12'h000, 12'(level));
    rd_chk("channel", 8'h00, 8'h28);
    rd_chk("status", 8'h01, 8'h00);
    rd_chk("irq config", 8'h02, 8'h00);
    rd_chk("power", 8'h03, 8'h00);
    rd_chk("strength", 8'h20, 8'h00);
    dev_acc(1'h0, 1'h1, 8'h04, 8'h00, b);
    chk("boost", 12'h011, 12'(b));
    $display("test defaults done");
  endtask
  // Channel bounds and carrier
  task automatic t_channel();
    logic [6:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 7'h7D : 7'h00;
      wr8(8'h00, {1'h0, v});
      rd_chk("channel", 8'h00, {1'h0, v});
      chk("channel pin", 12'(v), 12'(rf_ch));
      chk("carrier", 12'h960 + 12'(v), carrier);
    end
    $display("test channel done");
  endtask
  // Every power code, then the boost override
  task automatic t_power();
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      wr8(8'h03, 8'(i) << 2);
      chk("level", 12'(i), 12'(level));
    end
    dev_acc(1'h1, 1'h1, 8'h04, 8'h91, b);
    chk("boost level", 12'h004, 12'(level));
    dev_acc(1'h0, 1'h1, 8'h04, 8'h00, b);
    chk("boost read", 12'h091, 12'(b));
    dev_acc(1'h1, 1'h1, 8'h04, 8'h11, b);
    chk("boost off", 12'h003, 12'(level));
    $display("test power done");
  endtask
  // Each source except strength done sets, drives the pin and clears; mask and polarity
  task automatic t_irq();
    logic [7:0] m;
    wr8(8'h28, 8'h02);
    wr8(8'h02, 8'h3E);
    for (int s = 0; s < 5; s++) begin
      m = (s < 3) ? (8'h20 >> s) : (8'h02 >> (s - 3));
      case (s)
        0: rx_ready <= 1'h1;
        1: tx_done <= 1'h1;
        2: retry_lim <= 1'h1;
        3: txq <= 2'h2;
        default: rxq <= 1'h1;
      endcase
      @(posedge ref_clk);
      rx_ready <= 1'h0;
      tx_done <= 1'h0;
      retry_lim <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chk("irq set", 12'h000, 12'(irq_pin));
      rd_chk("flag", 8'h01, m);
      wr8(8'h01, m);
      rd_chk("flag clear", 8'h01, 8'h00);
      chk("irq clear", 12'h001, 12'(irq_pin));
    end
    txq <= 2'h0;
    rxq <= 1'h0;
    wr8(8'h02, 8'h1E);
    pulse_rx();
    chk("irq masked", 12'h001, 12'(irq_pin));
    rd_chk("masked flag", 8'h01, 8'h20);
    wr8(8'h02, 8'hA0);
    chk("irq high pol", 12'h001, 12'(irq_pin));
    wr8(8'h01, 8'h20);
    chk("irq high idle", 12'h000, 12'(irq_pin));
    wr8(8'h02, 8'h01);
    $display("test irq done");
  endtask
  // One-shot, continuous and packet strength
  task automatic t_strength();
    logic [7:0] b;
    int n;
    n = 0;
    strength <= 5'h0B;
    wr8(8'h20, 8'h10);
    chk("measuring", 12'h001, 12'(measuring));
    do begin
      dev_acc(1'h0, 1'h0, 8'h20, 8'h00, b);
      n++;
    end while (b[4] !== 1'h0 && n < 20);
    chk("oneshot result", 12'h045, 12'(b));
    chk("oneshot idle", 12'h000, 12'(measuring));
    rd_chk("done flag", 8'h01, 8'h04);
    chk("done irq", 12'h000, 12'(irq_pin));
    wr8(8'h01, 8'h04);
    strength <= 5'h14;
    wr8(8'h20, 8'h20);
    repeat (80) @(posedge ref_clk);
    rd_chk("cont result", 8'h20, 8'h2A);
    strength <= 5'h07;
    addr_match <= 1'h1;
    @(posedge ref_clk);
    addr_match <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk("packet strength", 12'h007, 12'(pkt_strength));
    wr8(8'h20, 8'h00);
    wr8(8'h01, 8'h04);
    repeat (80) @(posedge ref_clk);
    chk("stopped", 12'h000, 12'(measuring));
    rd_chk("no new done", 8'h01, 8'h00);
    $display("test strength done");
  endtask
  // Reset pin pulse mid-measurement restores defaults
  task automatic t_ext_reset();
    logic [31:0] q;
    int n;
    n = 0;
    wr8(8'h00, 8'h10);
    wr8(8'h20, 8'h20);
    av_acc(1'h1, 4'h8, 32'h1, q);
    while (idle !== 1'h0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("reset entered", 12'h000, 12'(idle));
    rd_chk("channel default", 8'h00, 8'h28);
    rd_chk("config default", 8'h02, 8'h00);
    chk("aborted", 12'h000, 12'(measuring));
    chk("back to idle", 12'h001, 12'(idle));
    chk("irq after reset", 12'h001, 12'(irq_pin));
    $display("test ext reset done");
  endtask
  // Main sequence
  initial begin
    reset_n = 1'h0;
    av_addr = 4'h0;
    av_rd = 1'h0;
    av_wr = 1'h0;
    av_wdata = 32'h0;
    {rx_ready, tx_done, retry_lim, rxq, addr_match} = 5'h00;
    txq = 2'h0;
    strength = 5'h00;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    // Device ignores the link until power-on ends
    while (idle !== 1'h1 && cyc < 200) @(posedge ref_clk);
    t_defaults();
    t_channel();
    t_power();
    t_irq();
    t_strength();
    t_ext_reset();
    final_report();
  end
endmodule // tb_radio_ctrl_irq_rssi_regs
